/* pkg/pix_pkg.sv */
// Constants, types and vector lookup for the peripheral interrupt expander
`default_nettype none
package pix_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PIX_SRC_COUNT = 16;
  localparam int PIX_IDX_W = 4;
  localparam int PIX_SEL_COUNT = 8;
  localparam int PIX_LVL_COUNT = 4;
  localparam int PIX_SYNC_W = 2;

  // ----------------------------------------------------------------
  // Source positions, ordered by priority within a level
  // ----------------------------------------------------------------
  localparam int SRC_POWER_DRIVE = 0;
  localparam int SRC_CONVERTER = 1;
  localparam int SRC_EXT_A = 2;
  localparam int SRC_EXT_B = 3;
  localparam int SRC_SYNC_SERIAL = 4;
  localparam int SRC_ASYNC_RX = 5;
  localparam int SRC_ASYNC_TX = 6;
  localparam int SRC_CAN_MAILBOX = 7;
  localparam int SRC_CAN_ERROR = 8;
  localparam int SRC_COMPARE_A = 9;
  localparam int SRC_COMPARE_B = 10;
  localparam int SRC_COMPARE_C = 11;
  localparam int SRC_TIMER_PERIOD = 12;
  localparam int SRC_TIMER_COMPARE = 13;
  localparam int SRC_TIMER_UNDER = 14;
  localparam int SRC_TIMER_OVER = 15;

  // ----------------------------------------------------------------
  // Level membership masks
  // ----------------------------------------------------------------
  localparam logic [PIX_SRC_COUNT-1:0] LVL_ONE_MASK = 16'h01FF;
  localparam logic [PIX_SRC_COUNT-1:0] LVL_TWO_MASK = 16'hFE00;
  localparam logic [PIX_SRC_COUNT-1:0] LVL_FIVE_MASK = 16'h01F0;
  localparam logic [PIX_SRC_COUNT-1:0] LVL_SIX_MASK = 16'h000E;
  localparam logic [PIX_SRC_COUNT-1:0] SELECTABLE_MASK = 16'h01FE;

  // ----------------------------------------------------------------
  // CPU vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_LVL_ONE = 16'h0002;
  localparam logic [15:0] VEC_LVL_TWO = 16'h0004;
  localparam logic [15:0] VEC_LVL_FIVE = 16'h000A;
  localparam logic [15:0] VEC_LVL_SIX = 16'h000C;
  localparam logic [15:0] VEC_NMI = 16'h0024;
  localparam logic [15:0] VEC_EMU_TRAP = 16'h0026;
  localparam logic [15:0] VEC_NONE = 16'hFFFF;

  // ----------------------------------------------------------------
  // Peripheral vector codes
  // ----------------------------------------------------------------
  localparam logic [15:0] PVEC_PHANTOM = 16'h0000;
  localparam logic [15:0] PVEC_POWER_DRIVE = 16'h0020;
  localparam logic [15:0] PVEC_CONVERTER = 16'h0004;
  localparam logic [15:0] PVEC_EXT_A = 16'h0001;
  localparam logic [15:0] PVEC_EXT_B = 16'h0011;
  localparam logic [15:0] PVEC_SYNC_SERIAL = 16'h0005;
  localparam logic [15:0] PVEC_ASYNC_RX = 16'h0006;
  localparam logic [15:0] PVEC_ASYNC_TX = 16'h0007;
  localparam logic [15:0] PVEC_CAN_MAILBOX = 16'h0040;
  localparam logic [15:0] PVEC_CAN_ERROR = 16'h0041;
  localparam logic [15:0] PVEC_COMPARE_A = 16'h0021;
  localparam logic [15:0] PVEC_COMPARE_B = 16'h0022;
  localparam logic [15:0] PVEC_COMPARE_C = 16'h0023;
  localparam logic [15:0] PVEC_TIMER_PERIOD = 16'h0027;
  localparam logic [15:0] PVEC_TIMER_COMPARE = 16'h0028;
  localparam logic [15:0] PVEC_TIMER_UNDER = 16'h0029;
  localparam logic [15:0] PVEC_TIMER_OVER = 16'h002A;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIX_ACK_ONE = 2'h0,
    PIX_ACK_TWO = 2'h1,
    PIX_ACK_FIVE = 2'h2,
    PIX_ACK_SIX = 2'h3
  } pix_ack_level_t;

  typedef struct packed {
    logic [15:0] vectorCode;
    logic vectorValid;
    logic [PIX_SRC_COUNT-1:0] ackClear;
    logic [15:0] topVector;
  } pix_top_state_t;

  typedef struct packed {
    logic [PIX_SYNC_W-1:0] stageOne;
    logic [PIX_SYNC_W-1:0] stageTwo;
  } pix_sync_state_t;

  // Peripheral vector code of a source position
  function automatic logic [15:0] pix_periph_vector(input logic [PIX_IDX_W-1:0] idx);
    logic [15:0] code;
    code = PVEC_PHANTOM;
    case (idx)
      4'h0: code = PVEC_POWER_DRIVE;
      4'h1: code = PVEC_CONVERTER;
      4'h2: code = PVEC_EXT_A;
      4'h3: code = PVEC_EXT_B;
      4'h4: code = PVEC_SYNC_SERIAL;
      4'h5: code = PVEC_ASYNC_RX;
      4'h6: code = PVEC_ASYNC_TX;
      4'h7: code = PVEC_CAN_MAILBOX;
      4'h8: code = PVEC_CAN_ERROR;
      4'h9: code = PVEC_COMPARE_A;
      4'hA: code = PVEC_COMPARE_B;
      4'hB: code = PVEC_COMPARE_C;
      4'hC: code = PVEC_TIMER_PERIOD;
      4'hD: code = PVEC_TIMER_COMPARE;
      4'hE: code = PVEC_TIMER_UNDER;
      4'hF: code = PVEC_TIMER_OVER;
      default: code = PVEC_PHANTOM;
    endcase
    return code;
  endfunction
endpackage
`default_nettype wire

/* pkg/pix_arb_if.sv */
// Request and winner carrier between the expander and one level arbiter
`timescale 1ns/10ps
`default_nettype none
interface pix_arb_if;
  import pix_pkg::*;
  logic [PIX_SRC_COUNT-1:0] req;
  logic any;
  logic [PIX_IDX_W-1:0] winIdx;
  modport arb (input req, output any, output winIdx);
  modport user (output req, input any, input winIdx);
endinterface
`default_nettype wire

/* design/pix_pin_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pix_pin_sync
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [pix_pkg::PIX_SYNC_W-1:0] pinIn,
  output logic [pix_pkg::PIX_SYNC_W-1:0] pinSync
);
  import pix_pkg::*;

  pix_sync_state_t state_q;
  pix_sync_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.stageOne = pinIn;
    state_d.stageTwo = state_q.stageOne;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pinSync = state_q.stageTwo;

  a_sync_two_stage: assert property (@(posedge core_clk) disable iff (reset)
    !$past(reset) && !$past(reset, 2) && $past(pinIn, 3) == $past(pinIn, 2)
      |-> ##0 pinSync == $past(pinIn, 2))
    else $error("pin synchroniser delay is not two cycles");
endmodule // pix_pin_sync
`default_nettype wire

/* design/pix_level_arbiter.sv */
// Fixed-priority arbiter for one CPU request level
`timescale 1ns/10ps
`default_nettype none
module pix_level_arbiter
(
  pix_arb_if.arb arbIf
);
  import pix_pkg::*;

  always_comb
  begin
    arbIf.any = |arbIf.req;
    arbIf.winIdx = '0;
    // Lowest position wins
    for (int i = PIX_SRC_COUNT - 1; i >= 0; i--)
    begin
      if (arbIf.req[i])
      begin
        arbIf.winIdx = PIX_IDX_W'(i);
      end
    end
  end

  a_lowest_wins: assert property (@(arbIf.req)
    arbIf.any |-> arbIf.req[arbIf.winIdx]
      && ((arbIf.req & ((PIX_SRC_COUNT'(1) << arbIf.winIdx) - PIX_SRC_COUNT'(1))) == '0))
    else $error("arbiter winner is not the lowest pending source");
endmodule // pix_level_arbiter
`default_nettype wire

/* design/pix_interrupt_expander.sv */
// Peripheral interrupt expander: maps peripheral requests onto CPU levels
`timescale 1ns/10ps
`default_nettype none
module pix_interrupt_expander
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic resetPin,
  input wire logic watchdogTimeout,
  input wire logic nmiPin,
  input wire logic emuTrap,
  input wire logic [pix_pkg::PIX_SRC_COUNT-1:0] srcFlag,
  input wire logic [pix_pkg::PIX_SRC_COUNT-1:0] srcEnable,
  input wire logic [pix_pkg::PIX_SEL_COUNT-1:0] srcHighPri,
  input wire logic cpuAck,
  input wire pix_pkg::pix_ack_level_t cpuAckLevel,
  output logic resetRequest,
  output logic nmiRequest,
  output logic cpuLevelOneRequest,
  output logic cpuLevelTwoRequest,
  output logic cpuLevelFiveRequest,
  output logic cpuLevelSixRequest,
  output logic [15:0] topVector,
  output logic [15:0] vectorCode,
  output logic vectorValid,
  output logic [pix_pkg::PIX_SRC_COUNT-1:0] ackClear
);
  import pix_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIX_SYNC_W-1:0] pinSync;
  logic resetPinSync;
  logic nmiPinSync;

  pix_pin_sync u_pin_sync
  (
    .core_clk(core_clk),
    .reset(reset),
    .pinIn({nmiPin, resetPin}),
    .pinSync(pinSync)
  );

  assign resetPinSync = pinSync[0];
  assign nmiPinSync = pinSync[1];

  // ----------------------------------------------------------------
  // Request gating and level routing
  // ----------------------------------------------------------------
  logic [PIX_SRC_COUNT-1:0] reqGated;
  logic [PIX_SRC_COUNT-1:0] highMode;
  logic [PIX_SRC_COUNT-1:0] lvlReq [PIX_LVL_COUNT];
  logic lvlAny [PIX_LVL_COUNT];
  logic [PIX_IDX_W-1:0] lvlIdx [PIX_LVL_COUNT];

  assign reqGated = srcFlag & srcEnable;
  assign highMode = ~SELECTABLE_MASK | {7'h00, srcHighPri, 1'b0};

  assign lvlReq[PIX_ACK_ONE] = reqGated & LVL_ONE_MASK & highMode;
  assign lvlReq[PIX_ACK_TWO] = reqGated & LVL_TWO_MASK;
  assign lvlReq[PIX_ACK_FIVE] = reqGated & LVL_FIVE_MASK & ~highMode;
  assign lvlReq[PIX_ACK_SIX] = reqGated & LVL_SIX_MASK & ~highMode;

  pix_arb_if lvlIf [PIX_LVL_COUNT] ();

  for (genvar g = 0; g < PIX_LVL_COUNT; g++)
  begin : g_level
    assign lvlIf[g].req = lvlReq[g];
    assign lvlAny[g] = lvlIf[g].any;
    assign lvlIdx[g] = lvlIf[g].winIdx;
    pix_level_arbiter u_arb
    (
      .arbIf(lvlIf[g])
    );
  end

  assign resetRequest = resetPinSync | watchdogTimeout;
  assign nmiRequest = nmiPinSync;
  assign cpuLevelOneRequest = lvlAny[PIX_ACK_ONE];
  assign cpuLevelTwoRequest = lvlAny[PIX_ACK_TWO];
  assign cpuLevelFiveRequest = lvlAny[PIX_ACK_FIVE];
  assign cpuLevelSixRequest = lvlAny[PIX_ACK_SIX];

  // ----------------------------------------------------------------
  // Acknowledge, vector fetch and top vector
  // ----------------------------------------------------------------
  pix_top_state_t state_q;
  pix_top_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.vectorValid = 1'b0;
    state_d.ackClear = '0;
    if (cpuAck)
    begin
      state_d.vectorValid = 1'b1;
      if (lvlAny[cpuAckLevel])
      begin
        state_d.vectorCode = pix_periph_vector(lvlIdx[cpuAckLevel]);
        state_d.ackClear = PIX_SRC_COUNT'(1) << lvlIdx[cpuAckLevel];
      end
      else
      begin
        state_d.vectorCode = PVEC_PHANTOM;
      end
    end
    // Fixed order: reset, emulator trap, NMI, then maskable levels
    if (resetRequest)
    begin
      state_d.topVector = VEC_RESET;
    end
    else if (emuTrap)
    begin
      state_d.topVector = VEC_EMU_TRAP;
    end
    else if (nmiRequest)
    begin
      state_d.topVector = VEC_NMI;
    end
    else if (lvlAny[PIX_ACK_ONE])
    begin
      state_d.topVector = VEC_LVL_ONE;
    end
    else if (lvlAny[PIX_ACK_TWO])
    begin
      state_d.topVector = VEC_LVL_TWO;
    end
    else if (lvlAny[PIX_ACK_FIVE])
    begin
      state_d.topVector = VEC_LVL_FIVE;
    end
    else if (lvlAny[PIX_ACK_SIX])
    begin
      state_d.topVector = VEC_LVL_SIX;
    end
    else
    begin
      state_d.topVector = VEC_NONE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q.vectorCode <= PVEC_PHANTOM;
      state_q.vectorValid <= 1'b0;
      state_q.ackClear <= '0;
      state_q.topVector <= VEC_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign topVector = state_q.topVector;
  assign vectorCode = state_q.vectorCode;
  assign vectorValid = state_q.vectorValid;
  assign ackClear = state_q.ackClear;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_top: assert property (@(posedge core_clk) disable iff (reset)
    resetRequest |=> topVector == VEC_RESET)
    else $error("reset did not take the top vector");

  a_nmi_third: assert property (@(posedge core_clk) disable iff (reset)
    nmiRequest && !resetRequest && !emuTrap |=> topVector == VEC_NMI)
    else $error("nmi did not vector to its location");

  a_power_drive_lvl: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_ONE && reqGated[SRC_POWER_DRIVE]
      |=> vectorCode == PVEC_POWER_DRIVE && topVector == VEC_LVL_ONE || $past(resetRequest)
        || $past(emuTrap) || $past(nmiRequest))
    else $error("power drive request not first on level one");

  a_flag_gating: assert property (@(posedge core_clk) disable iff (reset)
    reqGated == '0 |-> !cpuLevelOneRequest && !cpuLevelTwoRequest
      && !cpuLevelFiveRequest && !cpuLevelSixRequest)
    else $error("level request without gated flag");

  a_low_mode_route: assert property (@(posedge core_clk) disable iff (reset)
    reqGated == (PIX_SRC_COUNT'(1) << SRC_CONVERTER) && !srcHighPri[0]
      |-> cpuLevelSixRequest && !cpuLevelOneRequest)
    else $error("low priority converter request misrouted");

  a_compare_first: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_TWO && reqGated[SRC_COMPARE_A]
      |=> vectorValid && vectorCode == PVEC_COMPARE_A && ackClear[SRC_COMPARE_A])
    else $error("compare unit A not served first on level two");

  a_timer_period: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_TWO && reqGated[15:9] == 7'h08
      |=> vectorCode == PVEC_TIMER_PERIOD)
    else $error("timer period code wrong");

  a_single_cycle: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck ##1 !cpuAck |-> vectorValid ##1 !vectorValid)
    else $error("vector fetch not single cycle");

  a_ack_clear_one: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && lvlAny[cpuAckLevel] |=> $onehot(ackClear) ##1 ackClear == '0 || $past(cpuAck))
    else $error("acknowledge clear pulse malformed");

  a_converter_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_ONE && lvlAny[PIX_ACK_ONE]
      && lvlIdx[PIX_ACK_ONE] == PIX_IDX_W'(SRC_CONVERTER) |=> vectorCode == PVEC_CONVERTER)
    else $error("converter code wrong");

  a_ext_a_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_ONE && lvlAny[PIX_ACK_ONE]
      && lvlIdx[PIX_ACK_ONE] == PIX_IDX_W'(SRC_EXT_A) |=> vectorCode == PVEC_EXT_A)
    else $error("external pin A code wrong");

  a_ext_b_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_ONE && lvlAny[PIX_ACK_ONE]
      && lvlIdx[PIX_ACK_ONE] == PIX_IDX_W'(SRC_EXT_B) |=> vectorCode == PVEC_EXT_B)
    else $error("external pin B code wrong");

  a_sync_serial_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_ONE && lvlAny[PIX_ACK_ONE]
      && lvlIdx[PIX_ACK_ONE] == PIX_IDX_W'(SRC_SYNC_SERIAL) |=> vectorCode == PVEC_SYNC_SERIAL)
    else $error("sync serial code wrong");

  a_async_rx_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_ONE && lvlAny[PIX_ACK_ONE]
      && lvlIdx[PIX_ACK_ONE] == PIX_IDX_W'(SRC_ASYNC_RX) |=> vectorCode == PVEC_ASYNC_RX)
    else $error("async receive code wrong");

  a_async_tx_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_ONE && lvlAny[PIX_ACK_ONE]
      && lvlIdx[PIX_ACK_ONE] == PIX_IDX_W'(SRC_ASYNC_TX) |=> vectorCode == PVEC_ASYNC_TX)
    else $error("async transmit code wrong");

  a_can_mailbox_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_ONE && lvlAny[PIX_ACK_ONE]
      && lvlIdx[PIX_ACK_ONE] == PIX_IDX_W'(SRC_CAN_MAILBOX) |=> vectorCode == PVEC_CAN_MAILBOX)
    else $error("can mailbox code wrong");

  a_can_error_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_ONE && lvlAny[PIX_ACK_ONE]
      && lvlIdx[PIX_ACK_ONE] == PIX_IDX_W'(SRC_CAN_ERROR) |=> vectorCode == PVEC_CAN_ERROR)
    else $error("can error code wrong");

  a_timer_compare: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_TWO && lvlAny[PIX_ACK_TWO]
      && lvlIdx[PIX_ACK_TWO] == PIX_IDX_W'(SRC_TIMER_COMPARE) |=> vectorCode == PVEC_TIMER_COMPARE)
    else $error("timer compare code wrong");

  a_timer_under: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_TWO && lvlAny[PIX_ACK_TWO]
      && lvlIdx[PIX_ACK_TWO] == PIX_IDX_W'(SRC_TIMER_UNDER) |=> vectorCode == PVEC_TIMER_UNDER)
    else $error("timer underflow code wrong");

  a_timer_over: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_TWO && lvlAny[PIX_ACK_TWO]
      && lvlIdx[PIX_ACK_TWO] == PIX_IDX_W'(SRC_TIMER_OVER) |=> vectorCode == PVEC_TIMER_OVER)
    else $error("timer overflow code wrong");

  a_compare_b_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_TWO && lvlAny[PIX_ACK_TWO]
      && lvlIdx[PIX_ACK_TWO] == PIX_IDX_W'(SRC_COMPARE_B) |=> vectorCode == PVEC_COMPARE_B)
    else $error("compare unit B code wrong");

  a_compare_c_code: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && cpuAckLevel == PIX_ACK_TWO && lvlAny[PIX_ACK_TWO]
      && lvlIdx[PIX_ACK_TWO] == PIX_IDX_W'(SRC_COMPARE_C) |=> vectorCode == PVEC_COMPARE_C)
    else $error("compare unit C code wrong");

  a_phantom_ack: assert property (@(posedge core_clk) disable iff (reset)
    cpuAck && !lvlAny[cpuAckLevel] |=> vectorCode == PVEC_PHANTOM && ackClear == '0)
    else $error("empty level acknowledge not phantom");

  a_converter_route: assert property (@(posedge core_clk) disable iff (reset)
    reqGated[SRC_CONVERTER] && srcHighPri[SRC_CONVERTER - 1] |-> cpuLevelOneRequest)
    else $error("high priority converter not on level one");

  a_can_low_route: assert property (@(posedge core_clk) disable iff (reset)
    reqGated[SRC_CAN_ERROR] && !srcHighPri[SRC_CAN_ERROR - 1] |-> cpuLevelFiveRequest)
    else $error("low priority can error not on level five");

  a_ext_low_route: assert property (@(posedge core_clk) disable iff (reset)
    reqGated[SRC_EXT_B] && !srcHighPri[SRC_EXT_B - 1] |-> cpuLevelSixRequest)
    else $error("low priority external pin not on level six");
endmodule // pix_interrupt_expander
`default_nettype wire

/* tb/pix_cpu_model.sv */
// CPU-side acknowledge model facing the interrupt expander
`timescale 1ns/10ps
`default_nettype none
module pix_cpu_model
(
  input wire logic core_clk,
  output var logic cpuAck,
  output var pix_pkg::pix_ack_level_t cpuAckLevel
);
  import pix_pkg::*;

  initial
  begin
    cpuAck = 1'b0;
    cpuAckLevel = PIX_ACK_SIX;
  end

  // ----------------------------------------------------------------
  // Acknowledge one level after a delay, one-cycle pulse
  // ----------------------------------------------------------------
  task automatic ack(input pix_ack_level_t lvl, input int unsigned dly);
    repeat (dly) @(negedge core_clk);
    cpuAck = 1'b1;
    cpuAckLevel = lvl;
    @(negedge core_clk);
    cpuAck = 1'b0;
    cpuAckLevel = pix_ack_level_t'(~lvl);
  endtask
endmodule // pix_cpu_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the peripheral interrupt expander
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pix_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic resetPin = 1'b0;
  logic watchdogTimeout = 1'b0;
  logic nmiPin = 1'b0;
  logic emuTrap = 1'b0;
  logic [15:0] srcFlag = 16'h0000;
  logic [15:0] srcEnable = 16'h0000;
  logic [7:0] srcHighPri = 8'h00;
  logic cpuAck;
  pix_ack_level_t cpuAckLevel;
  logic resetRequest, nmiRequest, vectorValid;
  logic cpuLevelOneRequest, cpuLevelTwoRequest, cpuLevelFiveRequest, cpuLevelSixRequest;
  logic [15:0] topVector, vectorCode, ackClear;
  logic [31:0] expQ[$];
  logic [31:0] note;
  int n_fail = 0;
  int checked = 0;
  logic [15:0] codes[16] = '{16'h0020, 16'h0004, 16'h0001, 16'h0011, 16'h0005, 16'h0006, 16'h0007,
    16'h0040, 16'h0041, 16'h0021, 16'h0022, 16'h0023, 16'h0027, 16'h0028, 16'h0029, 16'h002A};

  always #20 core_clk = ~core_clk;

  pix_interrupt_expander i_pix_interrupt_expander (.core_clk, .reset, .resetPin, .watchdogTimeout,
    .nmiPin, .emuTrap, .srcFlag, .srcEnable, .srcHighPri, .cpuAck, .cpuAckLevel, .resetRequest,
    .nmiRequest, .cpuLevelOneRequest, .cpuLevelTwoRequest, .cpuLevelFiveRequest, .cpuLevelSixRequest,
    .topVector, .vectorCode, .vectorValid, .ackClear);

  pix_cpu_model i_pix_cpu_model (.core_clk, .cpuAck, .cpuAckLevel);

  // ----------------------------------------------------------------
  // Compare, expectation helpers, verdict
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Level requests {six, five, two, one} from gated requests and select mask
  function automatic logic [15:0] lv(input logic [15:0] g, input logic [15:0] s);
    lv = {12'h000, |(g & ~s & 16'h000E), |(g & ~s & 16'h01F0), |(g & 16'hFE00), |(g & s & 16'h01FF)};
  endfunction

  // Lowest position wins: {code, clear mask}, phantom when empty
  function automatic logic [31:0] pick(input logic [15:0] v);
    pick = 32'h00000000;
    for (int k = 15; k >= 0; k--)
      if (v[k])
        pick = {codes[k], 16'h0001 << k};
  endfunction

  task automatic doAck(input pix_ack_level_t l, input logic [31:0] n);
    expQ.push_back(n);
    i_pix_cpu_model.ack(l, 1 + $urandom % 3);
    chk("vectorValid", 16'h0001, {15'h0000, vectorValid});
  endtask

  task automatic serve();
    logic [15:0] g, s, done;
    logic [31:0] n;
    g = srcFlag & srcEnable;
    s = {7'h00, srcHighPri, 1'b1};
    done = 16'h0000;
    #1;
    chk("levels", lv(g, s), {12'h000, cpuLevelSixRequest, cpuLevelFiveRequest, cpuLevelTwoRequest,
      cpuLevelOneRequest});
    n = pick(g & s & 16'h01FF);
    doAck(PIX_ACK_ONE, n);
    done = done | n[15:0];
    n = pick(g & 16'hFE00);
    doAck(PIX_ACK_TWO, n);
    done = done | n[15:0];
    n = pick(g & ~s & 16'h01F0);
    doAck(PIX_ACK_FIVE, n);
    done = done | n[15:0];
    n = pick(g & ~s & 16'h000E);
    doAck(PIX_ACK_SIX, n);
    done = done | n[15:0];
    @(negedge core_clk);
    #1;
    chk("levelsAfter", lv(g & ~done, s), {12'h000, cpuLevelSixRequest, cpuLevelFiveRequest,
      cpuLevelTwoRequest, cpuLevelOneRequest});
  endtask

  task automatic tv(input logic [15:0] e);
    repeat (4) @(negedge core_clk);
    chk("topVector", e, topVector);
  endtask

  // ----------------------------------------------------------------
  // Result monitor: peripheral clears its flag on acknowledge
  // ----------------------------------------------------------------
  always @(negedge core_clk)
    if (vectorValid === 1'b1)
    begin
      note = (expQ.size() != 0) ? expQ.pop_front() : 32'hFFFFFFFF;
      chk("vectorCode", note[31:16], vectorCode);
      chk("ackClear", note[15:0], ackClear);
      srcFlag = srcFlag & ~ackClear;
    end

  initial
  begin
    #200000;
    n_fail++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h910A20B5));
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      @(negedge core_clk);
      srcHighPri = (i < 16) ? 8'hFF : 8'h00;
      srcEnable = 16'h0001 << (i % 16);
      srcFlag = 16'h0001 << (i % 16);
      serve();
    end
    for (int i = 0; i < 30; i++)
    begin
      @(negedge core_clk);
      srcHighPri = 8'($urandom);
      srcEnable = 16'($urandom);
      srcFlag = 16'($urandom);
      serve();
    end
    @(negedge core_clk);
    srcFlag = 16'h0000;
    srcEnable = 16'hFFFF;
    tv(16'hFFFF);
    srcFlag = 16'h1000;
    tv(16'h0004);
    srcFlag = 16'h1001;
    tv(16'h0002);
    nmiPin = 1'b1;
    tv(16'h0024);
    chk("nmiRequest", 16'h0001, {15'h0000, nmiRequest});
    emuTrap = 1'b1;
    tv(16'h0026);
    watchdogTimeout = 1'b1;
    #1;
    chk("resetRequest", 16'h0001, {15'h0000, resetRequest});
    tv(16'h0000);
    watchdogTimeout = 1'b0;
    resetPin = 1'b1;
    tv(16'h0000);
    chk("resetRequest", 16'h0001, {15'h0000, resetRequest});
    resetPin = 1'b0;
    nmiPin = 1'b0;
    emuTrap = 1'b0;
    tv(16'h0002);
    reset = 1'b1;
    tv(16'h0000);
    reset = 1'b0;
    tv(16'h0002);
    results();
  end
endmodule // tb_top
`default_nettype wire
